// ==== core/qdr_pkg.sv ====
package qdr_pkg;
	// target address upper five bits 1001_1, then the two address pins
	localparam logic [4:0] QDR_ADDR_UPPER = 5'h13;
	localparam logic [7:0] QDR_HS_CODE_MASK = 8'hF8;
	localparam logic [7:0] QDR_HS_CODE = 8'h08;
	localparam int QDR_FIFO_WIDTH = 16;
	localparam int QDR_FIFO_DEPTH = 32;
	localparam logic [1:0] QDR_MODE_STAGE = 2'h0;
	localparam logic [1:0] QDR_MODE_LOAD_ONE = 2'h1;
	localparam logic [1:0] QDR_MODE_LOAD_ALL = 2'h2;
	localparam logic [1:0] QDR_MODE_BCAST = 2'h3;
	localparam logic [13:0] QDR_REG_RESET = 14'h0000;
	localparam logic [2:0] QDR_BIT_RESET = 3'h0;
	typedef enum logic [5:0] {
		QDR_IDLE = 6'h01,
		QDR_ADDR = 6'h02,
		QDR_CTRL = 6'h04,
		QDR_HIGH = 6'h08,
		QDR_LOW = 6'h10,
		QDR_SKIP = 6'h20
	} qdr_state_t;
endpackage

// ==== core/qdr_fifo.sv ====
module qdr_fifo
	import qdr_pkg::*;
#(
	parameter int WIDTH = QDR_FIFO_WIDTH,
	parameter int DEPTH = QDR_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;
	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= AW'(wr_ff + 1'b1);
			end
			if (pop) begin
				rd_ff <= AW'(rd_ff + 1'b1);
			end
			cnt_ff <= (AW+1)'(cnt_ff + push - pop);
		end
	end
endmodule

// ==== core/qdr_receiver.sv ====
// Function
// - write begins with address byte, write flag clear, then control byte
// - control byte: two zeros, update mode, ignored bit, channel, powerdown flag
// - control lsb chooses powerdown data or conversion data
// - conversion data repeats high/low pairs until stop or repeated start
// - powerdown write takes exactly two bytes after control byte
// - low byte upper nibble holds bits three to zero; lower nibble ignored
// - acknowledge matching address, control and data bytes by pulling data low; high byte only while the fifo has room
// - never acknowledge the high-speed master code
// - after repeated start handle address, control, data as normal
// - apply word at falling edge of acknowledge clock after low byte
// - update mode: stage only, load selected, load all, broadcast
module qdr_receiver
	import qdr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_pin_hi,
	input wire logic addr_pin_lo,
	output logic [55:0] staging_register,
	output logic [55:0] output_register,
	output logic hs_mode,
	input wire logic word_ready,
	output logic word_valid,
	output logic [15:0] word_data
);
	// ==========================================================
	// pin synchronisers
	logic [1:0] scl_sync_ff;
	logic [1:0] sda_sync_ff;
	logic scl_d_ff;
	logic sda_d_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
			scl_d_ff <= scl_sync_ff[1];
			sda_d_ff <= sda_sync_ff[1];
		end
	end
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_s = scl_sync_ff[1];
	assign sda_s = sda_sync_ff[1];
	assign scl_rise = scl_s && !scl_d_ff;
	assign scl_fall = !scl_s && scl_d_ff;
	assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
	assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

	// ==========================================================
	// byte shifter and acknowledge slot
	qdr_state_t state_ff;
	logic [7:0] shift_ff;
	logic [3:0] bit_ff;
	logic ack_slot_ff;
	logic ack_drive_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] high_ff;
	logic pd_count_ff;
	logic byte_done;
	logic [7:0] byte_val;
	logic pend_ack_ff;
	logic pend_low_ff;
	logic fifo_ready;
	assign byte_done = scl_rise && (bit_ff == 4'h7) && !ack_slot_ff;
	assign byte_val = {shift_ff[6:0], sda_s};

	function automatic logic addr_match(input logic [7:0] b, input logic hi, input logic lo);
		return (b[7:3] == QDR_ADDR_UPPER) && (b[2] == hi) && (b[1] == lo) && !b[0];
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_ff <= 8'h00;
			bit_ff <= 4'h0;
			ack_slot_ff <= 1'b0;
		end else if (start_det || stop_det) begin
			bit_ff <= 4'h0;
			ack_slot_ff <= 1'b0;
		end else if (scl_rise && !ack_slot_ff) begin
			shift_ff <= byte_val;
			bit_ff <= (bit_ff == 4'h7) ? 4'h0 : 4'(bit_ff + 4'h1);
			ack_slot_ff <= (bit_ff == 4'h7);
		end else if (scl_fall && ack_slot_ff && bit_ff == 4'h0 && !ack_drive_ff) begin
			ack_slot_ff <= ack_slot_ff;
		end else if (scl_fall && ack_drive_ff) begin
			ack_slot_ff <= 1'b0;
		end else if (scl_rise && ack_slot_ff) begin
			ack_slot_ff <= 1'b0;
		end
	end

	// ==========================================================
	// transaction sequencing
	logic ack_now;
	logic low_done;
	always_comb begin
		ack_now = 1'b0;
		unique case (state_ff)
			QDR_ADDR: ack_now = addr_match(byte_val, addr_pin_hi, addr_pin_lo);
			QDR_CTRL: ack_now = 1'b1;
			QDR_HIGH: ack_now = fifo_ready;
			QDR_LOW: ack_now = 1'b1;
			QDR_IDLE: ack_now = 1'b0;
			QDR_SKIP: ack_now = 1'b0;
		endcase
	end
	assign low_done = byte_done && state_ff == QDR_LOW;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= QDR_IDLE;
			ctrl_ff <= 8'h00;
			high_ff <= 8'h00;
			pd_count_ff <= 1'b0;
			hs_mode <= 1'b0;
		end else if (stop_det) begin
			state_ff <= QDR_IDLE;
			hs_mode <= 1'b0;
		end else if (start_det) begin
			// every write starts at addressing; repeated start too
			state_ff <= QDR_ADDR;
		end else if (byte_done) begin
			unique case (state_ff)
				QDR_ADDR: begin
					if ((byte_val & QDR_HS_CODE_MASK) == QDR_HS_CODE) begin
						hs_mode <= 1'b1;
						state_ff <= QDR_SKIP;
					end else begin
						state_ff <= ack_now ? QDR_CTRL : QDR_SKIP;
					end
				end
				QDR_CTRL: begin
					ctrl_ff <= byte_val;
					pd_count_ff <= 1'b0;
					state_ff <= QDR_HIGH;
				end
				QDR_HIGH: begin
					high_ff <= byte_val;
					state_ff <= fifo_ready ? QDR_LOW : QDR_SKIP;
				end
				QDR_LOW: begin
					// loop pairs; two bytes for powerdown
					if (ctrl_ff[0]) begin
						pd_count_ff <= 1'b1;
						state_ff <= QDR_SKIP;
					end else begin
						state_ff <= QDR_HIGH;
					end
				end
				QDR_IDLE: state_ff <= QDR_IDLE;
				QDR_SKIP: state_ff <= QDR_SKIP;
			endcase
		end
	end

	// ==========================================================
	// acknowledge drive, released on the falling clock closing the slot
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_drive_ff <= 1'b0;
		end else if (start_det || stop_det) begin
			ack_drive_ff <= 1'b0;
		end else if (byte_done) begin
			ack_drive_ff <= 1'b0;
		end else if (scl_fall && ack_slot_ff && !ack_drive_ff && pend_ack_ff) begin
			ack_drive_ff <= 1'b1;
		end else if (scl_fall && ack_drive_ff) begin
			ack_drive_ff <= 1'b0;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_ack_ff <= 1'b0;
			pend_low_ff <= 1'b0;
		end else if (byte_done) begin
			pend_ack_ff <= ack_now;
			pend_low_ff <= low_done;
		end else if (scl_fall && ack_drive_ff) begin
			pend_ack_ff <= 1'b0;
			pend_low_ff <= 1'b0;
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = ack_drive_ff;

	// ==========================================================
	// word apply at the end of the acknowledge clock
	logic apply;
	logic [13:0] word;
	assign apply = scl_fall && ack_drive_ff && pend_low_ff;
	// lower nibble of low byte dropped; powerdown bits on top
	assign word = ctrl_ff[0] ? {high_ff[7:6], 12'h000} : {2'h0, high_ff, shift_ff[7:4]};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			staging_register <= {4{QDR_REG_RESET}};
			output_register <= {4{QDR_REG_RESET}};
		end else if (apply) begin
			// update mode picks which registers take the word
			unique case (ctrl_ff[5:4])
				QDR_MODE_STAGE: begin
					staging_register[ctrl_ff[2:1]*14 +: 14] <= word;
				end
				QDR_MODE_LOAD_ONE: begin
					staging_register[ctrl_ff[2:1]*14 +: 14] <= word;
					output_register[ctrl_ff[2:1]*14 +: 14] <= word;
				end
				QDR_MODE_LOAD_ALL: begin
					staging_register[ctrl_ff[2:1]*14 +: 14] <= word;
					output_register <= staging_register;
					output_register[ctrl_ff[2:1]*14 +: 14] <= word;
				end
				QDR_MODE_BCAST: begin
					if (ctrl_ff[2]) begin
						staging_register <= {4{word}};
						output_register <= {4{word}};
					end else begin
						output_register <= staging_register;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// received words streamed out; a full fifo refuses the high byte
	logic word_push_ff;
	logic [15:0] word_push_data_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_push_ff <= 1'b0;
			word_push_data_ff <= 16'h0000;
		end else begin
			word_push_ff <= apply && fifo_ready;
			word_push_data_ff <= {ctrl_ff[5:4], ctrl_ff[2:1], word[11:0]};
		end
	end
	logic out_v;
	logic [15:0] out_d;
	qdr_fifo #(.WIDTH(QDR_FIFO_WIDTH), .DEPTH(QDR_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(word_push_ff),
		.in_ready(fifo_ready),
		.in_data(word_push_data_ff),
		.out_valid(out_v),
		.out_ready(word_ready),
		.out_data(out_d)
	);
	assign word_valid = out_v;
	assign word_data = out_d;

	// ==========================================================
	// mismatch gives no drive
	no_ack_a: assert property (@(posedge clk) disable iff (rst)
		(byte_done && state_ff == QDR_SKIP) |=> !sda_oe [*8]) else $error("drive after skip");
	hs_noack_a: assert property (@(posedge clk) disable iff (rst)
		(byte_done && state_ff == QDR_ADDR && (byte_val & QDR_HS_CODE_MASK) == QDR_HS_CODE)
		|=> !sda_oe [*8]) else $error("master code acked");
	apply_ack_a: assert property (@(posedge clk) disable iff (rst)
		apply |-> $past(sda_oe)) else $error("apply outside ack");
	start_addr_a: assert property (@(posedge clk) disable iff (rst)
		start_det && !stop_det |=> state_ff == QDR_ADDR) else $error("start missed");
	pd_two_a: assert property (@(posedge clk) disable iff (rst)
		(low_done && ctrl_ff[0]) |=> state_ff == QDR_SKIP) else $error("pd overrun");
	pair_loop_a: assert property (@(posedge clk) disable iff (rst)
		(low_done && !ctrl_ff[0]) |=> state_ff == QDR_HIGH) else $error("pair loop");
	load_one_a: assert property (@(posedge clk) disable iff (rst)
		(apply && ctrl_ff[5:4] == QDR_MODE_LOAD_ONE) |=>
		output_register[$past(ctrl_ff[2:1])*14 +: 14] == $past(word)) else $error("load");
	stage_only_a: assert property (@(posedge clk) disable iff (rst)
		(apply && ctrl_ff[5:4] == QDR_MODE_STAGE) |=> $stable(output_register))
		else $error("stage moved output");
	ack_release_a: assert property (@(posedge clk) disable iff (rst)
		$rose(sda_oe) |-> !scl_s) else $error("ack driven high clock");
endmodule

// ==== verification/qdr_master.sv ====
module qdr_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_rel
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1;
		sda_rel = 1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// ==========
	// framing
	// with the clock low this is a repeated start
	task automatic start();
		sda_rel = 1;
		// let a pending acknowledge drop before the clock rises, else a stop appears
		tick(4);
		scl = 1;
		tick(4);
		sda_rel = 0;
		tick(4);
		scl = 0;
	endtask
	task automatic stop();
		tick(1);
		sda_rel = 0;
		tick(3);
		scl = 1;
		tick(4);
		sda_rel = 1;
		tick(4);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic [8:0] w;
		w = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			tick(1);
			sda_rel = w[i];
			tick(3);
			scl = 1;
			tick(2);
			ack = !sda;
			tick(2);
			scl = 0;
		end
	endtask
endmodule

// ==== verification/quad_dac_i2c_write_receiver_test.sv ====
module quad_dac_i2c_write_receiver_test;
	import qdr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic rst = 1;
	logic pin_hi = 0;
	logic pin_lo = 0;
	logic word_ready = 1;
	logic scl, sda_rel, sda, sda_out, sda_oe, hs, wv;
	logic [55:0] stg, outr;
	logic [15:0] wd;
	logic [15:0] exp_q[$];
	logic [13:0] st_m[4];
	logic [13:0] out_m[4];
	logic [31:0] r;
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 32'hEDD4;
	int cycles = 0;
	// pull-up on the data line, either side may pull it low
	assign sda = sda_rel && !(sda_oe && !sda_out);
	initial begin
		forever #10 clk = ~clk;
	end
	qdr_master m (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
	qdr_receiver DUT (
		.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_pin_hi(pin_hi), .addr_pin_lo(pin_lo),
		.staging_register(stg), .output_register(outr), .hs_mode(hs),
		.word_ready(word_ready), .word_valid(wv), .word_data(wd)
	);
	// ==========
	// checking
	task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (wv === 1'b1 && word_ready) begin
			check("word queued", 56'(exp_q.size() > 0), 1);
			if (exp_q.size() > 0) begin
				check("word", wd, exp_q.pop_front());
			end
		end
		if (cycles == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic put(input logic [7:0] b, input logic exp_ack);
		logic ack;
		m.send(b, ack);
		check("ack", ack, exp_ack);
	endtask
	task automatic regs_check();
		m.tick(6);
		for (int c = 0; c < 4; c++) begin
			check("staging", stg[c*14+:14], st_m[c]);
			check("output", outr[c*14+:14], out_m[c]);
		end
	endtask
	// ==========
	// transfers
	task automatic xfer(input logic [7:0] ctrl, input int n);
		logic [1:0] md;
		logic [1:0] ch;
		md = ctrl[5:4];
		ch = ctrl[2:1];
		put({QDR_ADDR_UPPER, pin_hi, pin_lo, 1'b0}, 1);
		put(ctrl, 1);
		repeat (n) begin
			r = $random(seed);
			put(r[11:4], 1);
			put({r[3:0], r[19:16]}, 1);
			exp_q.push_back({md, ch, r[11:0]});
			for (int c = 0; c < 4; c++) begin
				if ((md == QDR_MODE_BCAST && ch[1]) || (md != QDR_MODE_BCAST && c == ch)) begin
					st_m[c] = {2'b00, r[11:0]};
				end
				if (md[1] || (md[0] && c == ch)) begin
					out_m[c] = st_m[c];
				end
			end
		end
	endtask
	initial begin
		foreach (st_m[c]) begin
			st_m[c] = QDR_REG_RESET;
			out_m[c] = QDR_REG_RESET;
		end
		r = $random(seed);
		{pin_hi, pin_lo} = r[1:0];
		repeat (20) @(posedge clk);
		#2;
		rst = 0;
		regs_check();
		m.start();
		put({QDR_ADDR_UPPER, !pin_hi, pin_lo, 1'b0}, 0);
		put(8'h10, 0);
		m.stop();
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			m.start();
			xfer({2'b00, k[1:0], r[0], r[2] || k == 3, r[1], 1'b0}, 2);
			regs_check();
		end
		m.stop();
		r = $random(seed);
		m.start();
		put({QDR_HS_CODE[7:3], r[2:0]}, 0);
		check("hs", hs, 1);
		m.start();
		xfer({4'h1, 1'b0, r[4:3], 1'b0}, 1);
		m.stop();
		regs_check();
		check("hs", hs, 0);
		// full buffer refuses the next high byte while the drain stalls
		word_ready = 0;
		m.start();
		xfer(8'h00, 32);
		put(8'hA5, 0);
		m.stop();
		regs_check();
		word_ready = 1;
		repeat (80) @(posedge clk);
		#2;
		check("left", 56'(exp_q.size()), 0);
		// broadcast with control bit 2 clear only copies staging to outputs
		m.start();
		xfer(8'h30, 1);
		m.stop();
		regs_check();
		r = $random(seed);
		m.start();
		xfer({4'h1, 1'b0, r[1:0], 1'b1}, 0);
		exp_q.push_back({QDR_MODE_LOAD_ONE, r[1:0], 12'h000});
		put({r[3:2], 6'h00}, 1);
		put({4'h0, r[7:4]}, 1);
		put(8'h00, 0);
		m.stop();
		st_m[r[1:0]] = {r[3:2], 12'h000};
		out_m[r[1:0]] = st_m[r[1:0]];
		regs_check();
		tally_and_finish();
	end
endmodule
